// file: verilog/pwrdn_seq_cfg.svh
// Constants for the regulator power-down sequencer
`ifndef PWRDN_SEQ_CFG_SVH
`define PWRDN_SEQ_CFG_SVH
`define NUM_REGS      7
`define ORDER_W       3
`define ADDR_W        8
`define DATA_W        8
`define ADDR_BUCK1    8'h5F
`define ADDR_BUCK2    8'h60
`define ADDR_BUCK3    8'h61
`define ADDR_LDO1     8'h62
`define ADDR_LDO2     8'h63
`define ADDR_LDO3     8'h64
`define ADDR_MEMREF   8'h65
`define ORDER_ZERO    3'h0
`define ORDER_MAX     3'h7
`define STEP_CYCLES   16'h0010
`define STEP_W        16
`define ORDER_STEP    3'h1
`define STEP_LAST     16'h0001
`define STEP_DEC      16'h0001
`endif

// file: verilog/pwrdn_seq_pkg.sv
// Types shared by the power-down sequencer
`default_nettype none
`include "pwrdn_seq_cfg.svh"
package pwrdn_seq_pkg;
  typedef logic [`ORDER_W-1:0] order_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_STEP, SEQ_WAIT, SEQ_DONE}
    seq_state_t;
endpackage : pwrdn_seq_pkg
`default_nettype wire

// file: verilog/order_slot.sv
// One regulator's shutdown order field with a post-reset load from fuses
`default_nettype none
`include "pwrdn_seq_cfg.svh"
module order_slot
  import pwrdn_seq_pkg::*;
(
  input  wire logic   clock,     // System clock
  input  wire logic   rst_n,     // Async reset, active low
  input  wire logic   clkEn,     // Clock enable
  input  wire logic   loadFuse,  // Copy startup order in
  input  wire order_t fuseOrder, // Startup order, read only
  input  wire logic   wrEn,      // Accepted host write
  input  wire order_t wrData,    // Host write data
  output order_t      order      // Current shutdown order
);
  order_t order_reg;
  assign order = order_reg;

  // Fuse value is caught after reset release, never under reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      order_reg <= `ORDER_ZERO;
    end else if (clkEn) begin
      if (loadFuse) begin
        order_reg <= fuseOrder;
      end else if (wrEn) begin
        order_reg <= wrData;
      end
    end
  end
endmodule : order_slot
`default_nettype wire

// file: verilog/regulator_powerdown_sequencer.sv
// Power-down sequencer with per-regulator shutdown order registers
`default_nettype none
`include "pwrdn_seq_cfg.svh"
// Behaviour
// - Each regulator has 3-bit order field
// - Order fields reset to zero, then load power-up order after reset release
// - Disable regulators highest order value first
// - All zero orders: disable all at once
// - Host writes accepted only in on states
// - Power-up order fused, never register-writable
module regulator_powerdown_sequencer
  import pwrdn_seq_pkg::*;
#(
  parameter int NUM = `NUM_REGS
)(
  input  wire logic               clock,     // 20 MHz clock
  input  wire logic               rst_n,     // Async reset, active low
  input  wire logic               clkEn,     // Freezes state when low
  input  wire logic               systemOn,  // System in an on state
  input  wire logic               startDown, // Pulse: begin power-down
  input  wire logic [3*NUM-1:0]   fuseOrders,// Fused startup orders
  input  wire logic               regWrite,  // Register write strobe
  input  wire logic               regRead,   // Register read strobe
  input  wire logic [`ADDR_W-1:0] regAddr,   // Register address
  input  wire logic [`DATA_W-1:0] regWdata,  // Register write data
  output logic      [`DATA_W-1:0] regRdata,  // Read data, registered
  output logic                    rdValid,   // Read data valid pulse
  output logic      [NUM-1:0]     regEnable, // Regulator enables
  output logic                    seqBusy,   // Sequencer running
  output logic                    seqDone    // All regulators off
);
  localparam logic [`ADDR_W-1:0] ADDRS [`NUM_REGS] = '{
    `ADDR_BUCK1, `ADDR_BUCK2, `ADDR_BUCK3, `ADDR_LDO1,
    `ADDR_LDO2, `ADDR_LDO3, `ADDR_MEMREF};

  logic          loadPend_reg;
  order_t        order   [NUM];
  logic [NUM-1:0] hit;
  logic [NUM-1:0] wrHit;
  seq_state_t    state_reg;
  order_t        level_reg;
  logic [`STEP_W-1:0] timer_reg;
  logic          allZero;
  logic [NUM-1:0] stepMask;
  logic          startTaken; // Request accepted in idle
  logic          levelLast;  // Walk has reached order zero
  logic          levelDrop;  // Level still has regulators on
  logic          waitOver;   // Step delay has run out

  // Load fuses once, one cycle after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loadPend_reg <= 1'b1;
    end else if (clkEn) begin
      loadPend_reg <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_slot
      assign hit[i] = (regAddr == ADDRS[i]);
      // Writes ignored outside on states and while shutting down
      assign wrHit[i] = regWrite && hit[i] && systemOn
                        && (state_reg == SEQ_IDLE);
      assign stepMask[i] = (order[i] == level_reg);
      order_slot u_slot (
        .clock    (clock),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .loadFuse (loadPend_reg),
        .fuseOrder(order_t'(fuseOrders[`ORDER_W*i +: `ORDER_W])),
        .wrEn     (wrHit[i]),
        .wrData   (regWdata[`ORDER_W-1:0]),
        .order    (order[i])
      );
    end
  endgenerate

  always_comb begin
    allZero = 1'b1;
    for (int k = 0; k < NUM; k++) begin
      if (order[k] != `ORDER_ZERO) begin
        allZero = 1'b0;
      end
    end
  end

  // Read path: upper bits read zero, unmapped reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
      rdValid  <= 1'b0;
    end else if (clkEn) begin
      rdValid  <= regRead;
      regRdata <= '0;
      for (int k = 0; k < NUM; k++) begin
        if (regRead && hit[k]) begin
          regRdata <= {{(`DATA_W-`ORDER_W){1'b0}}, order[k]};
        end
      end
    end
  end

  // Step sequencer; each level is held STEP_CYCLES plus one cycle before the next
  // A request during the fuse load is dropped, not queued
  assign startTaken = (state_reg == SEQ_IDLE) && startDown
                      && !loadPend_reg;
  assign levelLast  = (level_reg == `ORDER_ZERO);
  assign levelDrop  = |(stepMask & regEnable);
  assign waitOver   = (timer_reg <= `STEP_LAST);

  // Sequencer state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEQ_IDLE;
    end else if (clkEn) begin
      case (state_reg)
        SEQ_IDLE: begin
          if (startTaken && allZero) begin
            state_reg <= SEQ_DONE;
          end else if (startTaken) begin
            state_reg <= SEQ_STEP;
          end
        end
        // Writes are refused outside idle, so the orders hold still here
        SEQ_STEP: begin
          if (levelLast) begin
            state_reg <= SEQ_DONE;
          end else if (levelDrop) begin
            state_reg <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (waitOver) begin
            state_reg <= SEQ_STEP;
          end
        end
        SEQ_DONE: begin
          // Stays off until reset, the normal wake path
          state_reg <= SEQ_DONE;
        end
        default: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Order level under service, walked from the top down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= `ORDER_MAX;
    end else if (clkEn) begin
      if (startTaken) begin
        level_reg <= `ORDER_MAX;
      end else if (state_reg == SEQ_STEP && !levelLast && !levelDrop) begin
        // Empty levels are skipped without a delay
        level_reg <= level_reg - `ORDER_STEP;
      end else if (state_reg == SEQ_WAIT && waitOver) begin
        level_reg <= level_reg - `ORDER_STEP;
      end
    end
  end

  // Step delay; loaded as a level drops, counted down while waiting
  // The drop edge plus the count gives one extra cycle per level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else if (clkEn) begin
      if (state_reg == SEQ_STEP && !levelLast && levelDrop) begin
        timer_reg <= `STEP_CYCLES;
      end else if (state_reg == SEQ_WAIT && !waitOver) begin
        timer_reg <= timer_reg - `STEP_DEC;
      end
    end
  end

  // Regulator enables only ever fall until the next reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regEnable <= '1;
    end else if (clkEn) begin
      if (startTaken && allZero) begin
        regEnable <= '0;
      end else if (state_reg == SEQ_STEP && levelLast) begin
        // Zero-order regulators go off with the last step
        regEnable <= '0;
      end else if (state_reg == SEQ_STEP && levelDrop) begin
        regEnable <= regEnable & ~stepMask;
      end
    end
  end

  // Busy covers the stepped walk only; the bypass never raises it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seqBusy <= 1'b0;
    end else if (clkEn) begin
      if (startTaken && !allZero) begin
        seqBusy <= 1'b1;
      end else if (state_reg == SEQ_STEP && levelLast) begin
        seqBusy <= 1'b0;
      end else if (state_reg == SEQ_DONE) begin
        seqBusy <= 1'b0;
      end
    end
  end

  // Done is sticky: power returns only through reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seqDone <= 1'b0;
    end else if (clkEn) begin
      if (startTaken && allZero) begin
        seqDone <= 1'b1;
      end else if (state_reg == SEQ_STEP && levelLast) begin
        seqDone <= 1'b1;
      end
    end
  end
endmodule : regulator_powerdown_sequencer
`default_nettype wire

// file: test/pwrdn_seq_properties.sv
// Port-level assertions for the power-down sequencer
`default_nettype none
module pwrdn_seq_properties #(parameter int NUM = 7) (
  input wire logic           clock,     // clock
  input wire logic           rst_n,     // reset
  input wire logic           clkEn,     // enable
  input wire logic           startDown, // start
  input wire logic           regRead,   // read
  input wire logic [7:0]     regRdata,  // data
  input wire logic           rdValid,   // valid
  input wire logic [NUM-1:0] regEnable, // enables
  input wire logic           seqBusy,   // busy
  input wire logic           seqDone    // done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A finished level must leave the enables alone for 8 cycles of its step wait
  sequence quiet8; $stable(regEnable)[*8]; endsequence
  a_read_answer:
    assert property (regRead && clkEn |=> rdValid) else $error("no read");
  a_high_zero:
    assert property (rdValid |-> regRdata[7:3] == 5'h00) else $error("hi");
  a_stay_off:
    assert property ((~$past(regEnable) & regEnable) == '0) else $error("on");
  a_on_idle:
    assert property (!seqBusy && !seqDone |-> &regEnable) else $error("off");
  a_start_taken:
    assert property (startDown && clkEn && !seqBusy && !seqDone
      |-> ##[1:2] (seqBusy || seqDone)) else $error("start");
  a_done_holds:
    assert property (seqDone |=> seqDone && !seqBusy) else $error("done");
  a_done_off:
    assert property ($rose(seqDone) |-> regEnable == '0) else $error("en");
  a_step_gap:
    assert property (seqBusy && regEnable != $past(regEnable) |=> quiet8)
      else $error("gap");
endmodule : pwrdn_seq_properties
`default_nettype wire

// file: test/regulator_powerdown_sequencer_tb.sv
// Bench for the power-down sequencer
`default_nettype none
module regulator_powerdown_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 0, rst_n = 0, systemOn = 1, startDown = 0, clkEn = 1;
  logic       regWrite = 0, regRead = 0, rdValid, seqBusy, seqDone;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [6:0] regEnable, prevEn = 7'h7F;
  logic [2:0] ord [7];
  int         failures = 0, cmpCount = 0, cycles = 0;
  regulator_powerdown_sequencer dut_u (.clock(clock), .rst_n(rst_n),
    .clkEn(clkEn), .systemOn(systemOn), .startDown(startDown),
    .fuseOrders(21'h04257B), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .rdValid(rdValid), .regEnable(regEnable), .seqBusy(seqBusy),
    .seqDone(seqDone));
  task automatic chk(input logic [7:0] g, e);
    cmpCount++;
    if (g !== e) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, e);
    @(negedge clock) {regRead, regAddr} = {1'b1, a};
    @(negedge clock) regRead = 0;
    chk(regRdata, e);
    chk({7'h00, rdValid}, 8'h01);
  endtask : rd
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock) {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(negedge clock) regWrite = 0;
  endtask : wr
  task automatic restart();
    rst_n = 0;
    repeat (20) @(negedge clock);
    rst_n = 1;
    repeat (2) @(negedge clock);
  endtask : restart
  task automatic go();
    @(negedge clock) startDown = 1;
    @(negedge clock) startDown = 0;
  endtask : go
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Whatever drops must outrank every regulator still on
  always @(negedge clock) begin
    for (int i = 0; i < 7; i++)
      for (int j = 0; j < 7; j++)
        if (prevEn[i] && !regEnable[i] && regEnable[j])
          chk({7'h00, ord[j] < ord[i]}, 8'h01);
    prevEn = regEnable;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    forever #25 clock = ~clock;
  end
  initial begin
    ord = '{3'h3, 3'h7, 3'h5, 3'h2, 3'h2, 3'h0, 3'h1};
    restart();
    for (int i = 0; i < 7; i++) rd(8'h5F + 8'(i), {5'h00, ord[i]});
    rd(8'h66, 8'h00);
    $display("defaults done");
    systemOn = 0;
    wr(8'h64, 8'h06);
    rd(8'h64, 8'h00);
    systemOn = 1;
    wr(8'h64, 8'hFA);
    ord[5] = 3'h2;
    rd(8'h64, 8'h02);
    $display("writes done");
    go();
    chk({7'h00, seqBusy}, 8'h01);
    for (int k = 0; k < 300 && !seqDone; k++) @(negedge clock);
    chk({seqDone, regEnable}, 8'h80);
    $display("stepped done");
    restart();
    rd(8'h64, 8'h00);
    for (int i = 0; i < 7; i++) wr(8'h5F + 8'(i), 8'h00);
    ord = '{default: 3'h0};
    clkEn = 0;
    go();
    chk({seqDone, regEnable}, 8'h7F);
    clkEn = 1;
    go();
    @(negedge clock);
    chk({seqDone, regEnable}, 8'h80);
    $display("bypass done");
    close_out();
  end
endmodule : regulator_powerdown_sequencer_tb
bind regulator_powerdown_sequencer pwrdn_seq_properties #(.NUM(NUM))
  props_u (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .startDown(startDown), .regRead(regRead), .regRdata(regRdata),
    .rdValid(rdValid), .regEnable(regEnable), .seqBusy(seqBusy),
    .seqDone(seqDone));
`default_nettype wire
